// ==== timer2_params.svh ====
`ifndef TIMER2_PARAMS_SVH
`define TIMER2_PARAMS_SVH

// Register offsets on the plain register port
`define OFS_TIMER_EXTENDED_STATUS_EXT     12'h411
`define OFS_T2_MODE_EXT   12'h419
`define OFS_T2_CONTROL    12'h418
`define OFS_COUNT_LOW     12'h4c0
`define OFS_COUNT_HIGH    12'h4c1
`define OFS_CAPTURE_LOW   12'h4c2
`define OFS_CAPTURE_HIGH  12'h4c3
`define OFS_RELOAD_LOW    12'h4c4
`define OFS_RELOAD_HIGH   12'h4c5
`define OFS_SYS_CONFIG    12'h440

// Field positions
`define BIT_T0_OUT_SEL    0
`define BIT_T1_OUT_SEL    2
`define BIT_DOWN_EN       0
`define BIT_CLK_OUT_EN    1
`define BIT_P1_TX_SRC     4
`define BIT_P1_RX_SRC     5
`define BIT_CAP_RELOAD    0
`define BIT_CNT_TIMER     1
`define BIT_RUN           2
`define BIT_EXT_TRIG_EN   3
`define BIT_P0_TX_SRC     4
`define BIT_P0_RX_SRC     5
`define BIT_EXT_FLAG      6
`define BIT_OVF_FLAG      7

// Reset value and the all-ones count value
`define RST_BYTE          8'h00
`define COUNT_ALL_ONES    16'hffff

// Prescaler divisions of the oscillator
`define PRESCALE_DIV4     8'd4
`define PRESCALE_DIV16    8'd16
`define PRESCALE_DIV64    8'd64
// Count pins are sampled every this many oscillator cycles
`define PIN_SAMPLE_CYCLES 8'd2
// Last roll-over count of the baud divider while clock-out runs
`define BAUD_DIV_LAST     3'h7

`endif

// ==== timer2_pkg.sv ====
package timer2_pkg;
  typedef enum logic [4:0] {
    MODE_OFF    = 5'b00001,
    MODE_RELOAD = 5'b00010,
    MODE_UPDOWN = 5'b00100,
    MODE_CAPTURE= 5'b01000,
    MODE_BAUD   = 5'b10000
  } t2_mode_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  typedef struct packed {
    logic port0_rx;
    logic port0_tx;
    logic port1_rx;
    logic port1_tx;
  } baud_route_s;
endpackage

// ==== timer2_capture_reload_clockout.sv ====
// Contract
// [R1] Timers 0 and 1 each toggle an output on every overflow.
// [R2] Output-select bits pick port data or toggle; cleared lets pin count.
// [R3] Timer 2 counts tick or pin events; overflow or underflow sets overflow flag.
// [R4] Run off stops; baud bit gives baud mode; else capture or reload.
// [R5] Capture mode: trigger falling edge copies count, sets external event flag.
// [R6] In capture mode external event flag requests interrupt like overflow flag.
// [R7] Auto-reload overflow loads the 16-bit reload value into the count.
// [R8] Auto-reload: trigger falling edge reloads count and sets external flag.
// [R9] Up/down enabled: trigger high counts up, low counts down.
// [R10] Counting up overflows past all ones, sets flag, reloads count.
// [R11] Counting down: count equal reload loads all ones, sets flag.
// [R12] Up/down mode: external event flag toggles on each wrap.
// [R13] Up/down mode: external event flag requests no interrupt.
// [R14] Baud generator advances on the prescaled tick.
// [R15] Per-port rx and tx source bits route timer 2 rate to ports.
// [R16] Clock out when timer select clear, clock-out enable and run set.
// [R17] Clock-out and baud mode roll-overs raise no interrupt.
// [R18] Baud and clock-out together; baud rate is clock-out rate over eight.
// [R19] Clock-out enable clear: pin counts; set: pin toggles per overflow.
// [R20] Prescaled tick is oscillator over 4, 16 or 64; code 3 reserved.
// [R21] Count pins sampled every 2 oscillator cycles; falling edges counted.
// [R22] Flags stay set until software clears them; hardware only sets. The code toggles the external event flag on each up/down wrap.
//
// Decided for this implementation: strobed register access.
`include "timer2_params.svh"
`timescale 1ns/1ps
`default_nettype none

module timer2_capture_reload_clockout (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  // Register port
  input  wire timer2_pkg::reg_req_s   reg_req,
  output logic [7:0]                  reg_rdata,
  // Overflow events of timers 0 and 1
  input  wire logic                   t0_overflow,
  input  wire logic                   t1_overflow,
  // Port data for the shared pins
  input  wire logic                   t0_port_data,
  input  wire logic                   t1_port_data,
  input  wire logic                   t2_port_data,
  // Pins
  input  wire logic                   t0_pin_in,
  input  wire logic                   t1_pin_in,
  input  wire logic                   clock_out_pin_in,
  input  wire logic                   external_trigger_input,
  output logic                        t0_pin_out,
  output logic                        t0_pin_oe,
  output logic                        t1_pin_out,
  output logic                        t1_pin_oe,
  output logic                        clock_out_pin_out,
  output logic                        clock_out_pin_oe,
  // Count strobes for timers 0 and 1 in counter mode
  output logic                        t0_count_pulse,
  output logic                        t1_count_pulse,
  // Timer 2 events and serial clocks
  output logic                        timer2_irq,
  output logic                        prescaled_tick,
  output timer2_pkg::baud_route_s     baud_route
);
  import timer2_pkg::*;

  logic [7:0]  timer_extended_status_reg;
  logic [7:0]  timer2_mode_extension_reg;
  logic [7:0]  timer2_control_reg;
  logic [1:0]  prescale_sel_reg;
  logic [15:0] count_reg;
  logic [15:0] capture_reg;
  logic [15:0] reload_reg;
  logic [7:0]  presc_cnt_reg;
  logic [7:0]  samp_cnt_reg;
  logic        t0_tog_reg;
  logic        t1_tog_reg;
  logic        t2_tog_reg;
  logic        baud_tog_reg;
  logic [2:0]  baud_div_reg;
  logic [3:0]  sync1_reg;
  logic [3:0]  sync2_reg;
  logic [3:0]  samp_reg;
  logic [7:0]  presc_div;
  logic        sample_now;
  logic        t0_fall;
  logic        t1_fall;
  logic        t2_fall;
  logic        trig_fall;
  logic        trig_level;
  logic        run;
  logic        baud_any;
  logic        clk_out_en;
  logic        count_step;
  logic        count_up;
  logic        wrap;
  logic        ext_event;
  logic        ovf_set;
  logic        ext_set;
  logic        ext_toggle;
  logic [15:0] count_next;
  t2_mode_e    mode;

  // Write strobe hitting one offset
  function automatic logic wr_hit(input reg_req_s r, input logic [11:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  // Prescaler selection
  always_comb begin
    unique case (prescale_sel_reg)
      2'd0:    presc_div = `PRESCALE_DIV4;  // [R20]
      2'd1:    presc_div = `PRESCALE_DIV16; // [R20]
      2'd2:    presc_div = `PRESCALE_DIV64; // [R20]
      default: presc_div = `PRESCALE_DIV64;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      presc_cnt_reg <= 8'h00;
    end else if (presc_cnt_reg >= presc_div - 8'h01) begin
      presc_cnt_reg <= 8'h00;
    end else begin
      presc_cnt_reg <= presc_cnt_reg + 8'h01;
    end
  end
  assign prescaled_tick = (presc_cnt_reg == 8'h00); // [R20]

  // Pin synchronisers and periodic sampling
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 4'hf;
      sync2_reg <= 4'hf;
    end else begin
      sync1_reg <= {external_trigger_input, clock_out_pin_in, t1_pin_in, t0_pin_in};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      samp_cnt_reg <= 8'h00;
      samp_reg     <= 4'hf;
    end else begin
      samp_cnt_reg <= sample_now ? 8'h00 : samp_cnt_reg + 8'h01;
      if (sample_now) begin
        samp_reg <= sync2_reg; // [R21]
      end
    end
  end
  assign sample_now = (samp_cnt_reg >= `PIN_SAMPLE_CYCLES - 8'h01); // [R21]
  assign t0_fall    = sample_now && samp_reg[0] && !sync2_reg[0]; // [R21]
  assign t1_fall    = sample_now && samp_reg[1] && !sync2_reg[1];
  assign t2_fall    = sample_now && samp_reg[2] && !sync2_reg[2];
  assign trig_fall  = sample_now && samp_reg[3] && !sync2_reg[3];
  assign trig_level = samp_reg[3];

  // Timers 0 and 1 pins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      t0_tog_reg <= 1'b0;
      t1_tog_reg <= 1'b0;
    end else begin
      if (t0_overflow) begin
        t0_tog_reg <= !t0_tog_reg; // [R1]
      end
      if (t1_overflow) begin
        t1_tog_reg <= !t1_tog_reg; // [R1]
      end
    end
  end
  assign t0_pin_oe      = timer_extended_status_reg[`BIT_T0_OUT_SEL]; // [R2]
  assign t1_pin_oe      = timer_extended_status_reg[`BIT_T1_OUT_SEL]; // [R2]
  assign t0_pin_out     = t0_pin_oe ? t0_tog_reg : t0_port_data;     // [R2]
  assign t1_pin_out     = t1_pin_oe ? t1_tog_reg : t1_port_data;     // [R2]
  assign t0_count_pulse = !t0_pin_oe && t0_fall; // [R2]
  assign t1_count_pulse = !t1_pin_oe && t1_fall; // [R2]

  // Timer 2 mode decode
  assign run        = timer2_control_reg[`BIT_RUN];
  assign clk_out_en = timer2_mode_extension_reg[`BIT_CLK_OUT_EN];
  assign baud_any   = timer2_control_reg[`BIT_P0_RX_SRC] | timer2_control_reg[`BIT_P0_TX_SRC]
                    | timer2_mode_extension_reg[`BIT_P1_RX_SRC]
                    | timer2_mode_extension_reg[`BIT_P1_TX_SRC];

  always_comb begin
    if (!run) begin
      mode = MODE_OFF; // [R4]
    end else if (baud_any) begin
      mode = MODE_BAUD; // [R4]
    end else if (timer2_control_reg[`BIT_CAP_RELOAD]) begin
      mode = MODE_CAPTURE; // [R4]
    end else if (timer2_mode_extension_reg[`BIT_DOWN_EN]) begin
      mode = MODE_UPDOWN; // [R4]
    end else begin
      mode = MODE_RELOAD; // [R4]
    end
  end

  // Count source: tick, or pin falling edge when the pin is an input
  always_comb begin
    if (mode == MODE_BAUD || clk_out_en) begin
      count_step = prescaled_tick; // [R14] [R16]
    end else if (timer2_control_reg[`BIT_CNT_TIMER]) begin
      count_step = t2_fall; // [R3] [R19]
    end else begin
      count_step = prescaled_tick; // [R3]
    end
  end

  // Count direction and external trigger events
  assign count_up  = (mode != MODE_UPDOWN) || trig_level; // [R9]
  assign ext_event = trig_fall && timer2_control_reg[`BIT_EXT_TRIG_EN]
                  && (mode == MODE_CAPTURE || mode == MODE_RELOAD); // [R5] [R8]

  // Next count value and roll-over detection
  always_comb begin
    wrap       = 1'b0;
    count_next = count_reg;
    if (mode != MODE_OFF && count_step) begin
      if (count_up) begin
        if (count_reg == `COUNT_ALL_ONES) begin
          wrap       = 1'b1;
          count_next = (mode == MODE_CAPTURE) ? 16'h0000 : reload_reg; // [R7] [R10]
        end else begin
          count_next = count_reg + 16'h0001;
        end
      end else if (count_reg == reload_reg) begin
        wrap       = 1'b1;
        count_next = `COUNT_ALL_ONES; // [R11]
      end else begin
        count_next = count_reg - 16'h0001;
      end
    end
    if (ext_event && mode == MODE_RELOAD) begin
      count_next = reload_reg; // [R8]
    end
  end

  // Flag events
  assign ovf_set    = wrap && mode != MODE_BAUD && !clk_out_en; // [R3] [R17]
  assign ext_set    = ext_event;                                 // [R5] [R8]
  assign ext_toggle = wrap && mode == MODE_UPDOWN;               // [R12]

  // Count and capture registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_reg   <= {`RST_BYTE, `RST_BYTE};
      capture_reg <= {`RST_BYTE, `RST_BYTE};
    end else begin
      if (wr_hit(reg_req, `OFS_COUNT_LOW)) begin
        count_reg <= {count_next[15:8], reg_req.wdata};
      end else if (wr_hit(reg_req, `OFS_COUNT_HIGH)) begin
        count_reg <= {reg_req.wdata, count_next[7:0]};
      end else begin
        count_reg <= count_next;
      end
      if (ext_event && mode == MODE_CAPTURE) begin
        capture_reg <= count_reg; // [R5]
      end else if (wr_hit(reg_req, `OFS_CAPTURE_LOW)) begin
        capture_reg[7:0] <= reg_req.wdata;
      end else if (wr_hit(reg_req, `OFS_CAPTURE_HIGH)) begin
        capture_reg[15:8] <= reg_req.wdata;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_extended_status_reg <= `RST_BYTE;
      timer2_mode_extension_reg <= `RST_BYTE;
      reload_reg                <= {`RST_BYTE, `RST_BYTE};
      prescale_sel_reg          <= 2'b00;
    end else begin
      if (wr_hit(reg_req, `OFS_TIMER_EXTENDED_STATUS_EXT)) begin
        timer_extended_status_reg <= reg_req.wdata & 8'h05;
      end
      if (wr_hit(reg_req, `OFS_T2_MODE_EXT)) begin
        timer2_mode_extension_reg <= reg_req.wdata & 8'h33;
      end
      if (wr_hit(reg_req, `OFS_RELOAD_LOW)) begin
        reload_reg[7:0] <= reg_req.wdata;
      end
      if (wr_hit(reg_req, `OFS_RELOAD_HIGH)) begin
        reload_reg[15:8] <= reg_req.wdata;
      end
      if (wr_hit(reg_req, `OFS_SYS_CONFIG)) begin
        prescale_sel_reg <= reg_req.wdata[1:0];
      end
    end
  end

  // Control register with sticky flags; hardware set wins over software clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer2_control_reg <= `RST_BYTE;
    end else begin
      if (wr_hit(reg_req, `OFS_T2_CONTROL)) begin
        timer2_control_reg <= reg_req.wdata;
      end
      if (ovf_set) begin
        timer2_control_reg[`BIT_OVF_FLAG] <= 1'b1; // [R22] [R3]
      end
      if (ext_set) begin
        timer2_control_reg[`BIT_EXT_FLAG] <= 1'b1; // [R22] [R5]
      end else if (ext_toggle) begin
        timer2_control_reg[`BIT_EXT_FLAG] <= !timer2_control_reg[`BIT_EXT_FLAG]; // [R12]
      end
    end
  end

  // Interrupt request from the sticky flags
  assign timer2_irq = timer2_control_reg[`BIT_OVF_FLAG]
                   || (timer2_control_reg[`BIT_EXT_FLAG] && mode != MODE_UPDOWN); // [R6] [R13]

  // Clock-out toggle, one change per roll-over
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      t2_tog_reg <= 1'b0;
    end else if (wrap) begin
      t2_tog_reg <= !t2_tog_reg; // [R19]
    end
  end

  // Baud clock; with clock-out on it runs at an eighth of the clock-out rate
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      baud_div_reg <= 3'h0;
      baud_tog_reg <= 1'b0;
    end else if (wrap) begin
      if (clk_out_en) begin
        baud_div_reg <= baud_div_reg + 3'h1; // [R18]
        if (baud_div_reg == `BAUD_DIV_LAST) begin
          baud_tog_reg <= !baud_tog_reg; // [R18]
        end
      end else begin
        baud_div_reg <= 3'h0;
        baud_tog_reg <= !baud_tog_reg;
      end
    end
  end

  // Pin drive and baud routing
  assign clock_out_pin_oe  = clk_out_en; // [R19]
  assign clock_out_pin_out = (clk_out_en && run && !timer2_control_reg[`BIT_CNT_TIMER])
                           ? t2_tog_reg : t2_port_data; // [R16]
  assign baud_route.port0_rx = timer2_control_reg[`BIT_P0_RX_SRC] && baud_tog_reg; // [R15]
  assign baud_route.port0_tx = timer2_control_reg[`BIT_P0_TX_SRC] && baud_tog_reg; // [R15]
  assign baud_route.port1_rx = timer2_mode_extension_reg[`BIT_P1_RX_SRC] && baud_tog_reg; // [R15]
  assign baud_route.port1_tx = timer2_mode_extension_reg[`BIT_P1_TX_SRC] && baud_tog_reg; // [R15]

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        `OFS_TIMER_EXTENDED_STATUS_EXT:    reg_rdata <= timer_extended_status_reg;
        `OFS_T2_MODE_EXT:  reg_rdata <= timer2_mode_extension_reg;
        `OFS_T2_CONTROL:   reg_rdata <= timer2_control_reg;
        `OFS_COUNT_LOW:    reg_rdata <= count_reg[7:0];
        `OFS_COUNT_HIGH:   reg_rdata <= count_reg[15:8];
        `OFS_CAPTURE_LOW:  reg_rdata <= capture_reg[7:0];
        `OFS_CAPTURE_HIGH: reg_rdata <= capture_reg[15:8];
        `OFS_RELOAD_LOW:   reg_rdata <= reload_reg[7:0];
        `OFS_RELOAD_HIGH:  reg_rdata <= reload_reg[15:8];
        `OFS_SYS_CONFIG:   reg_rdata <= {6'h00, prescale_sel_reg};
        default:           reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

`default_nettype wire

// ==== timer2_capture_reload_clockout_asserts.sv ====
`include "timer2_params.svh"
`timescale 1ns/1ps
`default_nettype none

module timer2_checker (
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 rstn,
  // Register port
  input wire timer2_pkg::reg_req_s reg_req,
  input wire logic [7:0]           reg_rdata,
  // Pins and events
  input wire logic                 t0_overflow,
  input wire logic                 t1_overflow,
  input wire logic                 t0_pin_out,
  input wire logic                 t0_pin_oe,
  input wire logic                 t1_pin_out,
  input wire logic                 t1_pin_oe,
  input wire logic                 clock_out_pin_oe,
  input wire logic                 prescaled_tick
);
  import timer2_pkg::*;
  logic [7:0] wd;
  logic       wr_stat;
  logic       rd_stat;
  logic       wr_mode;
  logic       rd_mode;
  assign wd = reg_req.wdata;
  assign wr_stat = reg_req.wr && reg_req.addr == `OFS_TIMER_EXTENDED_STATUS_EXT;
  assign rd_stat = reg_req.rd && reg_req.addr == `OFS_TIMER_EXTENDED_STATUS_EXT;
  assign wr_mode = reg_req.wr && reg_req.addr == `OFS_T2_MODE_EXT;
  assign rd_mode = reg_req.rd && reg_req.addr == `OFS_T2_MODE_EXT;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_t0_sel_write: assert property ($past(wr_stat) |-> t0_pin_oe == $past(wd[0]))
    else $error("timer 0 output select not applied");
  a_t1_sel_write: assert property ($past(wr_stat) |-> t1_pin_oe == $past(wd[2]))
    else $error("timer 1 output select not applied");
  a_stat_read_back: assert property ($past(rd_stat) |->
    reg_rdata == {5'h00, $past(t1_pin_oe), 1'b0, $past(t0_pin_oe)})
    else $error("status read differs from pin selects");
  a_clkout_en_write: assert property ($past(wr_mode) |-> clock_out_pin_oe == $past(wd[1]))
    else $error("clock-out enable not applied");
  a_mode_read_back: assert property ($past(rd_mode) |-> reg_rdata[1] == $past(clock_out_pin_oe)
    && reg_rdata[7:6] == 2'b00 && reg_rdata[3:2] == 2'b00)
    else $error("mode read differs from clock-out enable");
  a_t0_toggle: assert property (t0_pin_oe && t0_overflow ##1 t0_pin_oe |->
    t0_pin_out != $past(t0_pin_out))
    else $error("timer 0 pin did not toggle");
  a_t0_hold: assert property (t0_pin_oe && !t0_overflow ##1 t0_pin_oe |-> $stable(t0_pin_out))
    else $error("timer 0 pin moved without overflow");
  a_t1_toggle: assert property (t1_pin_oe && t1_overflow ##1 t1_pin_oe |->
    t1_pin_out != $past(t1_pin_out))
    else $error("timer 1 pin did not toggle");
  a_tick_gap: assert property (prescaled_tick |=> !prescaled_tick [*3])
    else $error("tick closer than four clocks");
  a_tick_bound: assert property (prescaled_tick |-> ##[4:64] prescaled_tick)
    else $error("tick missing for over 64 clocks");

  c_toggle: cover property (t0_pin_oe && t0_overflow);
  c_stat_read: cover property ($past(rd_stat));
  c_clock_out: cover property (clock_out_pin_oe && prescaled_tick);
endmodule

bind timer2_capture_reload_clockout timer2_checker chk_i (
  .clk_sys, .rstn, .reg_req, .reg_rdata, .t0_overflow, .t1_overflow, .t0_pin_out,
  .t0_pin_oe, .t1_pin_out, .t1_pin_oe, .clock_out_pin_oe, .prescaled_tick
);
`default_nettype wire

// ==== timer2_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module timer2_pin_model (
  // Clock
  input  wire logic       clk_sys,
  // Drive from the block
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  // Levels seen on the pins
  output logic [2:0]      pin_level,
  output logic            trig
);
  logic [2:0] src_reg = 3'h7;
  initial trig = 1'b1;
  // Pulled-up pins follow the block only while it drives them
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & src_reg);
  // Falling edge on a count pin, each level held for hold clocks
  task automatic fall_pulse(input int idx, input int hold);
    @(posedge clk_sys);
    src_reg[idx] <= 1'b0;
    repeat (hold) @(posedge clk_sys);
    src_reg[idx] <= 1'b1;
    repeat (hold) @(posedge clk_sys);
  endtask
  task automatic drive_trig(input logic lvl, input int hold);
    @(posedge clk_sys);
    trig <= lvl;
    repeat (hold) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ==== timer2_capture_reload_clockout_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module timer2_capture_reload_clockout_tb;
  import timer2_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  reg_req_s    reg_req = '0;
  logic [7:0]  reg_rdata;
  logic        t0_overflow = 1'b0;
  logic        t1_overflow = 1'b0;
  logic [2:0]  port_data = 3'h5;
  wire  [2:0]  pin_out;
  wire  [2:0]  pin_oe;
  wire  [2:0]  pin_level;
  wire         trig;
  logic        t0_count_pulse;
  logic        t1_count_pulse;
  logic        timer2_irq;
  logic        prescaled_tick;
  baud_route_s baud_route;
  int          bad_count = 0;
  int          checks_done = 0;
  int          pulse_cnt = 0;

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    pulse_cnt <= pulse_cnt + int'(t0_count_pulse) + int'(t1_count_pulse);
  end

  timer2_capture_reload_clockout DUT (
    .clk_sys(clk_sys), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .t0_overflow(t0_overflow), .t1_overflow(t1_overflow), .t0_port_data(port_data[0]),
    .t1_port_data(port_data[1]), .t2_port_data(port_data[2]), .t0_pin_in(pin_level[0]),
    .t1_pin_in(pin_level[1]), .clock_out_pin_in(pin_level[2]), .external_trigger_input(trig),
    .t0_pin_out(pin_out[0]), .t0_pin_oe(pin_oe[0]), .t1_pin_out(pin_out[1]),
    .t1_pin_oe(pin_oe[1]), .clock_out_pin_out(pin_out[2]), .clock_out_pin_oe(pin_oe[2]),
    .t0_count_pulse(t0_count_pulse), .t1_count_pulse(t1_count_pulse),
    .timer2_irq(timer2_irq), .prescaled_tick(prescaled_tick), .baud_route(baud_route)
  );
  timer2_pin_model pins (
    .clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level), .trig(trig)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(e));
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (timer2_irq !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (n >= lim) begin
      bad_count++;
      $display("[FAIL] %0t interrupt never came", $time);
      stop_test();
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: sig = pin_out[2];
      1: sig = baud_route.port1_rx;
      default: sig = prescaled_tick;
    endcase
  endfunction
  // Clocks from the first change to the third: a full period of a level or a pulse train
  task automatic period(input int s, output int n);
    logic v;
    int   k;
    int   t;
    k = 0;
    t = 0;
    n = 0;
    @(posedge clk_sys);
    #1 v = sig(s);
    while (k < 3 && t < 5000) begin
      @(posedge clk_sys);
      #1 t++;
      if (k >= 1) n++;
      if (sig(s) !== v) begin
        k++;
        v = sig(s);
      end
    end
    if (t >= 5000) begin
      bad_count++;
      $display("[FAIL] %0t signal %0d stuck", $time, s);
      stop_test();
    end
  endtask

  task automatic test_regs();
    rchk(12'h411, 8'h00);
    rchk(12'h419, 8'h00);
    rchk(12'h418, 8'h00);
    rchk(12'h400, 8'h00);
    wr(12'h411, 8'hff);
    rchk(12'h411, 8'h05);
    wr(12'h419, 8'hff);
    rchk(12'h419, 8'h33);
    wr(12'h419, 8'h00);
    $display("register test done");
  endtask
  task automatic test_toggle();
    logic [1:0] e;
    int         c;
    #1 e = pin_out[1:0];
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      t0_overflow <= 1'b1;
      t1_overflow <= i[0];
      @(posedge clk_sys);
      t0_overflow <= 1'b0;
      t1_overflow <= 1'b0;
      #1 e = e ^ {i[0], 1'b1};
      chk(16'(pin_out[1:0]), 16'(e));
    end
    wr(12'h411, 8'h00);
    port_data <= 3'h2;
    repeat (2) @(posedge clk_sys);
    #1 chk(16'({pin_oe, pin_out}), 16'h0002);
    c = pulse_cnt;
    pins.fall_pulse(0, 2);
    pins.fall_pulse(0, 3);
    pins.fall_pulse(1, 2);
    repeat (6) @(posedge clk_sys);
    chk(16'(pulse_cnt - c), 16'h0003);
    $display("toggle test done");
  endtask
  task automatic test_prescaler();
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(12'h440, 8'(c));
      period(2, n);
      period(2, n);
      chk(16'(n), 16'(c == 3 ? 64 : 4 << (2 * c)));
    end
    $display("prescaler test done");
  endtask
  task automatic test_reload();
    for (int dir = 0; dir < 3; dir++) begin
      wr(12'h419, {7'h00, dir != 0});
      pins.drive_trig(dir != 2, 2);
      wr(12'h4c4, 8'h10);
      wr(12'h4c5, 8'h00);
      wr(12'h4c0, dir == 2 ? 8'h12 : 8'hfe);
      wr(12'h4c1, dir == 2 ? 8'h00 : 8'hff);
      wr(12'h418, 8'h04);
      wait_irq(400);
      rchk(12'h418, {1'b1, dir != 0, 6'h04});
      rchk(12'h4c0, dir == 2 ? 8'hff : 8'h10);
      rchk(12'h4c1, dir == 2 ? 8'hff : 8'h00);
      wr(12'h418, 8'h44);
      #1 chk(16'(timer2_irq), 16'(dir == 0));
      wr(12'h418, 8'h00);
    end
    $display("reload test done");
  endtask
  task automatic test_capture();
    pins.drive_trig(1'b1, 4);
    wr(12'h419, 8'h00);
    wr(12'h4c0, 8'h00);
    wr(12'h4c1, 8'h55);
    wr(12'h418, 8'h0d);
    pins.drive_trig(1'b0, 8);
    rchk(12'h4c3, 8'h55);
    rchk(12'h418, 8'h4d);
    chk(16'(timer2_irq), 16'h0001);
    wr(12'h418, 8'h00);
    $display("capture test done");
  endtask
  task automatic test_ext_reload();
    pins.drive_trig(1'b1, 4);
    wr(12'h4c4, 8'h34);
    wr(12'h4c5, 8'h12);
    wr(12'h4c0, 8'h00);
    wr(12'h4c1, 8'h80);
    wr(12'h418, 8'h0e);
    pins.fall_pulse(2, 2);
    pins.fall_pulse(2, 3);
    rchk(12'h4c0, 8'h02);
    pins.drive_trig(1'b0, 8);
    rchk(12'h4c0, 8'h34);
    rchk(12'h4c1, 8'h12);
    rchk(12'h418, 8'h4e);
    wr(12'h418, 8'h00);
    $display("external reload test done");
  endtask
  task automatic test_clockout();
    logic [1:0] tx;
    int         n;
    int         m;
    wr(12'h4c4, 8'hfe);
    wr(12'h4c5, 8'hff);
    wr(12'h4c0, 8'hfe);
    wr(12'h4c1, 8'hff);
    wr(12'h419, 8'h22);
    wr(12'h418, 8'h24);
    #1 tx = {baud_route.port0_tx, baud_route.port1_tx};
    chk(16'(pin_oe[2]), 16'h0001);
    chk(16'(tx), 16'h0000);
    period(0, n);
    chk(16'(n), 16'd256);
    period(1, m);
    chk(16'(m), 16'(8 * n));
    rchk(12'h418, 8'h24);
    chk(16'({baud_route.port0_tx, baud_route.port1_tx}), 16'h0000);
    chk(16'(baud_route.port0_rx), 16'(baud_route.port1_rx));
    $display("clock-out test done");
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    test_regs();
    test_toggle();
    test_prescaler();
    test_reload();
    test_capture();
    test_ext_reload();
    test_clockout();
    stop_test();
  end
endmodule
`default_nettype wire
